// ---- pkg/rfl_pkg.sv ----
`default_nettype none
package rfl_pkg;

   // Register bus shape
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE_CLEAR = 8'h06;
   localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE_SET   = 8'h07;
   localparam logic [ADDR_W-1:0] OFF_IRQ_FLAGS        = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_SYNC_STATUS      = 8'h0A;

   // Field positions, shared by enable and flag registers; BIT_SYNC_BUSY is in the sync status register
   localparam int BIT_OVERFLOW  = 7;
   localparam int BIT_SYNC_DONE = 6;
   localparam int BIT_CMP_ONE   = 1;
   localparam int BIT_CMP_ZERO  = 0;
   localparam int BIT_ALARM     = 0;
   localparam int BIT_SYNC_BUSY = 7;

   // Implemented bits per counter mode
   localparam logic [DATA_W-1:0] MASK_COUNT32  = 8'hC1;
   localparam logic [DATA_W-1:0] MASK_COUNT16  = 8'hC3;
   localparam logic [DATA_W-1:0] MASK_CALENDAR = 8'hC1;
   localparam logic [DATA_W-1:0] MASK_NONE     = 8'h00;

   localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;

   typedef enum logic [1:0] {
      MODE_COUNT32  = 2'b00,
      MODE_COUNT16  = 2'b01,
      MODE_CALENDAR = 2'b10,
      MODE_RESERVED = 2'b11
   } rfl_mode_type;

   typedef enum logic [1:0] {
      SYNC_IDLE  = 2'b00,
      SYNC_BUSY  = 2'b01,
      SYNC_QUIET = 2'b10
   } rfl_sync_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } rfl_bus_req_type;

   typedef struct packed {
      logic overflow;
      logic compare_zero_match;
      logic compare_one_match;
      logic alarm_zero_match;
   } rfl_events_type;

   typedef struct packed {
      logic start;
      logic quiet;
      logic complete;
   } rfl_sync_req_type;

   typedef struct packed {
      logic [DATA_W-1:0] enable;
      logic [DATA_W-1:0] flags;
      logic [DATA_W-1:0] pending;
      rfl_sync_type      sync;
      logic              busy;
      logic [DATA_W-1:0] rdata;
      logic              irq;
   } rfl_state_type;

endpackage
`default_nettype wire

// ---- logic/rfl_irq_flags.sv ----
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module rfl_irq_flags (
   // Clock and reset
   input  wire  logic                      clk,
   input  wire  logic                      resetn,
   // Counter mode and counter-clock tick
   input  wire  logic [1:0]                counter_mode,
   input  wire  logic                      counter_tick,
   // Events from the counter datapath
   input  wire  rfl_pkg::rfl_events_type   events,
   // Synchronizer handshake
   input  wire  rfl_pkg::rfl_sync_req_type sync_req,
   // Register port
   input  wire  rfl_pkg::rfl_bus_req_type  bus_req,
   output logic [rfl_pkg::DATA_W-1:0]      bus_rdata,
   // Status and interrupt
   output logic                            sync_busy_bit,
   output logic                            irq
);
   import rfl_pkg::*;

   rfl_state_type     state_reg;
   rfl_state_type     state_next;
   rfl_mode_type      mode;
   logic [DATA_W-1:0] mask;
   logic [DATA_W-1:0] event_vec;
   logic [DATA_W-1:0] set_vec;
   logic [DATA_W-1:0] flag_clear;
   logic [DATA_W-1:0] enable_set;
   logic [DATA_W-1:0] enable_clear;
   logic [DATA_W-1:0] status_view;
   logic              sync_done_set;

   assign mode = rfl_mode_type'(counter_mode);

   // Bits present in the active layout
   always_comb begin
      case (mode)
         MODE_COUNT32:  mask = MASK_COUNT32;
         MODE_COUNT16:  mask = MASK_COUNT16;
         MODE_CALENDAR: mask = MASK_CALENDAR;
         default:       mask = MASK_NONE;
      endcase
   end

   // Map datapath events onto the flag layout of the active mode
   always_comb begin
      event_vec = RESET_BYTE;
      event_vec[BIT_OVERFLOW] = events.overflow;
      case (mode)
         MODE_COUNT32: begin
            event_vec[BIT_CMP_ZERO] = events.compare_zero_match;
         end
         MODE_COUNT16: begin
            event_vec[BIT_CMP_ZERO] = events.compare_zero_match;
            event_vec[BIT_CMP_ONE]  = events.compare_one_match;
         end
         MODE_CALENDAR: begin
            event_vec[BIT_ALARM] = events.alarm_zero_match;
         end
         default: begin
            event_vec = RESET_BYTE;
         end
      endcase
   end

   // Write decode: only ones act, zeros leave bits alone
   always_comb begin
      enable_set   = RESET_BYTE;
      enable_clear = RESET_BYTE;
      flag_clear   = RESET_BYTE;
      if (bus_req.wr) begin
         case (bus_req.addr)
            OFF_IRQ_ENABLE_SET:   enable_set   = bus_req.wdata & mask;
            OFF_IRQ_ENABLE_CLEAR: enable_clear = bus_req.wdata & mask;
            OFF_IRQ_FLAGS:        flag_clear   = bus_req.wdata & mask;
            default:              flag_clear   = RESET_BYTE;
         endcase
      end
   end

   assign status_view = {state_reg.busy, 7'h00};

   always_comb begin
      state_next    = state_reg;
      sync_done_set = 1'b0;

      // Sync busy tracking; a quiet sync came from enable or software reset
      case (state_reg.sync)
         SYNC_IDLE: begin
            if (sync_req.start) begin
               state_next.sync = sync_req.quiet ? SYNC_QUIET : SYNC_BUSY;
            end
         end
         SYNC_BUSY: begin
            if (sync_req.complete) begin
               state_next.sync = SYNC_IDLE;
               sync_done_set   = 1'b1;
            end
         end
         SYNC_QUIET: begin
            if (sync_req.complete) begin
               state_next.sync = SYNC_IDLE;
            end
         end
         default: begin
            state_next.sync = SYNC_IDLE;
         end
      endcase
      state_next.busy = (state_next.sync != SYNC_IDLE);

      // Events wait for the next counter tick; an event seen on a tick
      // belongs to that tick's cycle and so lands on the following one
      if (counter_tick) begin
         set_vec            = state_reg.pending & mask;
         state_next.pending = event_vec;
      end else begin
         set_vec            = RESET_BYTE;
         state_next.pending = state_reg.pending | event_vec;
      end
      set_vec[BIT_SYNC_DONE] = set_vec[BIT_SYNC_DONE] | sync_done_set;

      // Set is applied after clear so a colliding event is never lost
      state_next.flags = ((state_reg.flags & ~flag_clear) | set_vec)
                         & mask;

      // One enable store behind both set and clear addresses
      state_next.enable = ((state_reg.enable | enable_set) & ~enable_clear)
                          & mask;

      // Registered request follows flags and enables of the same edge
      state_next.irq = |(state_next.flags & state_next.enable);

      // Read data stands only in the cycle after the strobe
      state_next.rdata = RESET_BYTE;
      if (bus_req.rd) begin
         case (bus_req.addr)
            OFF_IRQ_ENABLE_SET: begin
               state_next.rdata = state_reg.enable & mask;
            end
            OFF_IRQ_ENABLE_CLEAR: begin
               state_next.rdata = state_reg.enable & mask;
            end
            OFF_IRQ_FLAGS: begin
               state_next.rdata = state_reg.flags & mask;
            end
            OFF_SYNC_STATUS: begin
               state_next.rdata = status_view;
            end
            default: begin
               state_next.rdata = RESET_BYTE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_reg.enable  <= RESET_BYTE;
         state_reg.flags   <= RESET_BYTE;
         state_reg.pending <= RESET_BYTE;
         state_reg.sync    <= SYNC_IDLE;
         state_reg.busy    <= 1'b0;
         state_reg.rdata   <= RESET_BYTE;
         state_reg.irq     <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign bus_rdata     = state_reg.rdata;
   assign sync_busy_bit = state_reg.busy;
   assign irq           = state_reg.irq;

endmodule // rfl_irq_flags
`default_nettype wire

// ---- testbench/rfl_irq_flags_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module rfl_irq_flags_monitor (
   // Clock and reset
   input wire logic                      clk,
   input wire logic                      resetn,
   // Counter side
   input wire logic [1:0]                counter_mode,
   input wire logic                      counter_tick,
   input wire rfl_pkg::rfl_events_type   events,
   input wire rfl_pkg::rfl_sync_req_type sync_req,
   // Register port and outputs
   input wire rfl_pkg::rfl_bus_req_type  bus_req,
   input wire logic [7:0]                bus_rdata,
   input wire logic                      sync_busy_bit,
   input wire logic                      irq
);
   import rfl_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_rd(a); bus_req.rd && bus_req.addr == a; endsequence
   sequence s_end; sync_busy_bit && sync_req.complete; endsequence
   property p_status;
      s_rd(8'h0A) |=> bus_rdata == {$past(sync_busy_bit), 7'h00}; endproperty
   a_status: assert property (p_status) else $error("status read");
   property p_rsv_flags; s_rd(8'h08) |=> bus_rdata[5:2] == 4'h0; endproperty
   a_rsv_flags: assert property (p_rsv_flags) else $error("flag bits");
   property p_rsv_enable; s_rd(8'h07) |=> bus_rdata[5:2] == 4'h0 &&
      (!bus_rdata[1] || $past(counter_mode) == 2'b01); endproperty
   a_rsv_enable: assert property (p_rsv_enable) else $error("enables");
   property p_start; sync_req.start && !sync_busy_bit |=> sync_busy_bit;
   endproperty
   a_start: assert property (p_start) else $error("busy not set");
   property p_end; s_end |=> !sync_busy_bit; endproperty
   a_end: assert property (p_end) else $error("busy not cleared");
   property p_hold; sync_busy_bit && !sync_req.complete |=> sync_busy_bit;
   endproperty
   a_hold: assert property (p_hold) else $error("busy dropped");
   // Mode changes clear stored bits outside the new mask, so they count as a cause too
   property p_irq_rise; $rose(irq) |-> $past(counter_tick) ||
      $past(bus_req.wr) || $fell(sync_busy_bit) ||
      $past(counter_mode) != $past(counter_mode, 2); endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("irq rose");
   property p_irq_fall; $fell(irq) |-> $past(bus_req.wr) ||
      $past(counter_mode) != $past(counter_mode, 2); endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell");
endmodule // rfl_irq_flags_monitor
bind rfl_irq_flags rfl_irq_flags_monitor u_rfl_irq_flags_monitor (
   .clk(clk), .resetn(resetn), .counter_mode(counter_mode),
   .counter_tick(counter_tick), .events(events), .sync_req(sync_req),
   .bus_req(bus_req), .bus_rdata(bus_rdata),
   .sync_busy_bit(sync_busy_bit), .irq(irq));
`default_nettype wire

// ---- testbench/rfl_irq_flags_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
   $display("CHECK FAILED t=%0t got %h want %h", $time, g, e); end end
module rfl_irq_flags_tb;
   import rfl_pkg::*;
   logic             clk = 1'b0;
   logic             resetn = 1'b0;
   logic [1:0]       counter_mode = 2'b00;
   logic             counter_tick = 1'b0;
   rfl_events_type   events = '0;
   rfl_sync_req_type sync_req = '0;
   rfl_bus_req_type  bus_req = '0;
   logic [7:0]       bus_rdata;
   logic             sync_busy_bit;
   logic             irq;
   int               err_total = 0;
   int               check_count = 0;
   int               cyc = 0;
   always #10 clk = ~clk;
   rfl_irq_flags u_rfl_irq_flags (.clk(clk), .resetn(resetn),
      .counter_mode(counter_mode), .counter_tick(counter_tick),
      .events(events), .sync_req(sync_req), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .sync_busy_bit(sync_busy_bit), .irq(irq));
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // One cycle of stimulus, then everything back to idle
   task automatic drv(input logic [7:0] a, d, input logic [1:0] wr_rd,
         input logic tk, input logic [3:0] e, input logic [2:0] s);
      @(posedge clk);
      bus_req <= '{addr: a, wdata: d, wr: wr_rd[1], rd: wr_rd[0]};
      counter_tick <= tk;
      events <= e;
      sync_req <= s;
      @(posedge clk);
      bus_req <= '0;
      counter_tick <= 1'b0;
      events <= '0;
      sync_req <= '0;
   endtask
   task automatic wr(input logic [7:0] a, d);
      drv(a, d, 2'b10, 1'b0, 4'h0, 3'h0);
   endtask
   task automatic rd(input logic [7:0] a, exp);
      drv(a, 8'h00, 2'b01, 1'b0, 4'h0, 3'h0);
      #1 `CHK(bus_rdata, exp)
   endtask
   // Event first, tick two cycles later so the flag lands on that tick
   task automatic ev(input logic [3:0] e);
      drv(8'h00, 8'h00, 2'b00, 1'b0, e, 3'h0);
      drv(8'h00, 8'h00, 2'b00, 1'b1, 4'h0, 3'h0);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         err_total++;
         conclude();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      rd(8'h06, 8'h00);
      rd(8'h08, 8'h00);
      rd(8'h0B, 8'h00);
      $display("test reset done");
      counter_mode <= MODE_COUNT16;
      wr(8'h07, 8'hFF);
      rd(8'h07, 8'hC3);
      wr(8'h07, 8'h00);
      wr(8'h06, 8'h01);
      rd(8'h07, 8'hC2);
      wr(8'h0A, 8'hFF);
      rd(8'h0A, 8'h00);
      ev(4'hF);
      rd(8'h08, 8'h83);
      #1 `CHK(irq, 1'b1)
      wr(8'h08, 8'h00);
      rd(8'h08, 8'h83);
      wr(8'h08, 8'h01);
      rd(8'h08, 8'h82);
      drv(8'h00, 8'h00, 2'b00, 1'b0, 4'h4, 3'h0);
      drv(8'h08, 8'h01, 2'b10, 1'b1, 4'h0, 3'h0);
      rd(8'h08, 8'h83);
      wr(8'h06, 8'hFE);
      #1 `CHK(irq, 1'b0)
      $display("test two compare done");
      wr(8'h08, 8'hFF);
      counter_mode <= MODE_CALENDAR;
      wr(8'h07, 8'hFF);
      rd(8'h06, 8'hC1);
      ev(4'h6);
      rd(8'h08, 8'h00);
      ev(4'h1);
      rd(8'h08, 8'h01);
      wr(8'h08, 8'hFF);
      counter_mode <= MODE_COUNT32;
      ev(4'h3);
      rd(8'h08, 8'h00);
      ev(4'h4);
      rd(8'h08, 8'h01);
      #1 `CHK(irq, 1'b1)
      $display("test modes done");
      wr(8'h08, 8'hFF);
      wr(8'h06, 8'h81);
      drv(8'h00, 8'h00, 2'b00, 1'b0, 4'h0, 3'b100);
      rd(8'h0A, 8'h80);
      drv(8'h00, 8'h00, 2'b00, 1'b0, 4'h0, 3'b001);
      rd(8'h08, 8'h40);
      #1 `CHK(irq, 1'b1)
      wr(8'h08, 8'h40);
      drv(8'h00, 8'h00, 2'b00, 1'b0, 4'h0, 3'b110);
      drv(8'h00, 8'h00, 2'b00, 1'b0, 4'h0, 3'b001);
      rd(8'h08, 8'h00);
      rd(8'h0A, 8'h00);
      $display("test sync done");
      conclude();
   end
endmodule // rfl_irq_flags_tb
`default_nettype wire
